// File: design/pin_power_event_map.vh
/*
 header: register offsets, field positions, reset values for the pin and power event flag block.
 assumes: included by bare name from design files of this block only.
*/
`ifndef PIN_POWER_EVENT_MAP_VH
`define PIN_POWER_EVENT_MAP_VH
`define MASKS_ADDR 8'h0F
`define FLAGS_ADDR 8'h12
`define FLAG_PIN_HI 7
`define FLAG_PIN_LO 4
`define FLAG_BUCK 3
`define FLAG_LINREG 2
`define FLAG_BUTTON 1
`define FLAG_RSVD 0
`define FLAGS_RESET 8'h00
`define MASKS_RESET 8'hFF
`define DEGLITCH_CYCLES 4'h2
`endif

// File: design/edge_catch.v
/*
 holds: two-flop synchroniser with edge detector for one asynchronous level.
 assumes: clk_i is the block clock; nrst_i asynchronous active low.
*/
`timescale 1ns/1ps
`include "pin_power_event_map.vh"
module edge_catch (
   input wire clk_i,
   input wire nrst_i,
   input wire level_i,
   output wire rise_o,
   output wire fall_o,
   output wire level_o
);
   reg meta_q;
   reg sync_q;
   reg prev_q;
   // prev starts at zero: a pin already high at reset shows one rise
   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         prev_q <= 1'b0;
      end else begin
         meta_q <= level_i;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end
   assign rise_o = sync_q & ~prev_q;
   assign fall_o = ~sync_q & prev_q;
   assign level_o = sync_q;
endmodule

// File: design/gpio_power_event_flags.v
/*
 holds: read-to-clear pin and power event flag register, its mask register and the fault reset.
 assumes: a simple same-clock register port (addr, wdata, write and read strobes) from the serial
 control interface; event inputs are asynchronous pins.
*/
`timescale 1ns/1ps
`include "pin_power_event_map.vh"
module gpio_power_event_flags #(
   parameter PIN_COUNT = 4
) (
   input wire clk_i,
   input wire nrst_i,
   input wire undervoltage_or_device_reset_i,
   input wire [PIN_COUNT-1:0] pin_levels_i,
   input wire buck_output_low_n_i,
   input wire linreg_output_low_n_i,
   input wire push_button_state_i,
   input wire [7:0] reg_addr_i,
   input wire [7:0] reg_wdata_i,
   input wire reg_write_i,
   input wire reg_read_i,
   output reg [7:0] reg_rdata_o,
   output reg reg_rvalid_o,
   output reg [7:0] pin_power_event_flags_o,
   output reg fault_reset_o
);
   reg [7:0] pin_power_event_masks_q;
   reg [7:0] flags_d;
   reg [7:0] rdata_d;
   reg [1:0] uv_sync_q;
   wire [7:0] rise;
   wire [7:0] fall;
   wire [7:0] lvl;
   wire [7:0] src;
   wire [7:0] evt;
   wire uv_clear;
   wire flags_read;
   wire masks_write;

   assign src = {pin_levels_i[3:0], buck_output_low_n_i, linreg_output_low_n_i, push_button_state_i, 1'b0};

   genvar g;
   generate
      for (g = 1; g < 8; g = g + 1) begin : g_src
         edge_catch u_edge (
            .clk_i(clk_i),
            .nrst_i(nrst_i),
            .level_i(src[g]),
            .rise_o(rise[g]),
            .fall_o(fall[g]),
            .level_o(lvl[g])
         );
      end
   endgenerate
   assign rise[0] = 1'b0;
   assign fall[0] = 1'b0;
   assign lvl[0] = 1'b0;

   // pins and button flag either edge, unmasked only
   assign evt[7:4] = (rise[7:4] | fall[7:4]) & ~pin_power_event_masks_q[7:4];
   // power flags on fault rising edge only; mask not applied to power flags
   assign evt[3:2] = rise[3:2];
   assign evt[1] = (rise[1] | fall[1]) & ~pin_power_event_masks_q[1];
   assign evt[0] = 1'b0;

   // undervoltage input is a pin; sync before use
   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         uv_sync_q <= 2'h0;
      end else begin
         uv_sync_q <= {uv_sync_q[0], undervoltage_or_device_reset_i};
      end
   end
   assign uv_clear = uv_sync_q[1];

   assign flags_read = reg_read_i && (reg_addr_i == `FLAGS_ADDR);
   assign masks_write = reg_write_i && (reg_addr_i == `MASKS_ADDR);

   // set wins over read-clear so a same-cycle event is kept
   always @* begin
      flags_d = pin_power_event_flags_o;
      if (flags_read) begin
         flags_d = 8'h00;
      end
      flags_d = flags_d | evt;
      flags_d[`FLAG_RSVD] = 1'b0;
   end

   always @* begin
      rdata_d = 8'h00;
      case (reg_addr_i)
         `FLAGS_ADDR: rdata_d = pin_power_event_flags_o;
         `MASKS_ADDR: rdata_d = {pin_power_event_masks_q[7:1], 1'b1};
         default: rdata_d = 8'h00;
      endcase
   end

   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         pin_power_event_flags_o <= `FLAGS_RESET;
         pin_power_event_masks_q <= `MASKS_RESET;
         reg_rdata_o <= 8'h00;
         reg_rvalid_o <= 1'b0;
         fault_reset_o <= 1'b0;
      end else begin
         reg_rvalid_o <= reg_read_i;
         reg_rdata_o <= reg_read_i ? rdata_d : 8'h00;
         if (uv_clear) begin
            pin_power_event_flags_o <= `FLAGS_RESET;
            pin_power_event_masks_q <= `MASKS_RESET;
         end else begin
            pin_power_event_flags_o <= flags_d;
            if (masks_write) begin
               pin_power_event_masks_q <= reg_wdata_i;
            end
         end
         // any low output, however caused (oversized step up), resets; level held while low
         // no step check on writes: downward changes need none
         fault_reset_o <= lvl[`FLAG_BUCK] | lvl[`FLAG_LINREG];
      end
   end
endmodule

// File: test/flag_props.sv
/* checker on flag block ports
 assumes bind below */
`timescale 1ns/1ps
module flag_props #(parameter PIN_COUNT = 4) (
   input wire clk_i,
   input wire nrst_i,
   input wire undervoltage_or_device_reset_i,
   input wire [PIN_COUNT-1:0] pin_levels_i,
   input wire buck_output_low_n_i,
   input wire linreg_output_low_n_i,
   input wire [7:0] reg_addr_i,
   input wire reg_read_i,
   input wire [7:0] reg_rdata_o,
   input wire reg_rvalid_o,
   input wire [7:0] pin_power_event_flags_o,
   input wire fault_reset_o
);
   wire [7:0] f = pin_power_event_flags_o;
   wire rd = reg_read_i && reg_addr_i == 8'h12;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   a_buck_sets: assert property ($rose(buck_output_low_n_i) |-> ##3 f[3]) else $error("buck");
   a_lin_sets: assert property ($rose(linreg_output_low_n_i) |-> ##3 f[2]) else $error("lin");
   a_fault_reset: assert property ($rose(buck_output_low_n_i) |-> ##3 fault_reset_o) else $error("rst");
   a_bit0_zero: assert property (!f[0]) else $error("bit0");
   a_read_data: assert property (rd |=> reg_rvalid_o && reg_rdata_o == $past(f)) else $error("rd");
   a_read_clear: assert property (rd |=> (f & $past(f)) == 8'h00) else $error("clr");
   a_uv_clears: assert property (undervoltage_or_device_reset_i [*4] |-> f == 8'h00) else $error("uv");
   a_pin_cause: assert property ($rose(f[4]) |-> $past(pin_levels_i[0], 3) != $past(pin_levels_i[0], 4))
      else $error("pin");
   c_read: cover property (rd && f != 8'h00);
   c_fault: cover property (fault_reset_o);
   c_uv: cover property (undervoltage_or_device_reset_i [*4]);
endmodule
bind gpio_power_event_flags flag_props #(.PIN_COUNT(PIN_COUNT)) u_props (.*);

// File: test/host_port.sv
/* host model on the register port
 assumes one clock; answer read after edge */
`timescale 1ns/1ps
module host_port (
   input wire clk_i,
   input wire [7:0] rdata_i,
   output reg [7:0] addr_o = 8'h00,
   output reg [7:0] wdata_o = 8'h00,
   output reg wr_o = 1'b0,
   output reg rd_o = 1'b0
);
   // no voltage writes, so no upward step
   task acc(input w, input [7:0] a, input [7:0] d, output [7:0] q);
      @(posedge clk_i);
      addr_o <= a;
      wdata_o <= d;
      wr_o <= w;
      rd_o <= !w;
      @(posedge clk_i);
      wr_o <= 1'b0;
      rd_o <= 1'b0;
      addr_o <= ~a;
      #1 q = rdata_i;
   endtask
endmodule

// File: test/gpio_power_event_flags_bench.sv
/* bench: register tests of the flag block
 assumes host_port drives the port */
`timescale 1ns/1ps
module gpio_power_event_flags_bench;
   reg clk_i = 1'b0;
   reg nrst_i = 1'b0;
   reg uv = 1'b0;
   reg [6:0] ev = 7'h00;
   reg [7:0] d;
   wire [7:0] a, w, q, f;
   wire wr, rd, fr;
   integer err_total = 0, samples_checked = 0, cyc = 0, i;
   initial forever #5 clk_i = ~clk_i;
   always @(posedge clk_i) if (++cyc == 3000) begin
      err_total++;
      finish_test;
   end
   host_port u_host (.clk_i(clk_i), .rdata_i(q), .addr_o(a), .wdata_o(w), .wr_o(wr), .rd_o(rd));
   gpio_power_event_flags u_dut (.clk_i(clk_i), .nrst_i(nrst_i), .undervoltage_or_device_reset_i(uv),
      .pin_levels_i(ev[3:0]), .push_button_state_i(ev[4]), .buck_output_low_n_i(ev[5]),
      .linreg_output_low_n_i(ev[6]), .reg_addr_i(a), .reg_wdata_i(w), .reg_write_i(wr), .reg_read_i(rd),
      .reg_rdata_o(q), .reg_rvalid_o(), .pin_power_event_flags_o(f), .fault_reset_o(fr));
   task chk(input string n, input [7:0] e, input [7:0] g);
      samples_checked++;
      if (g !== e) begin
         err_total++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask
   task rdc(input [7:0] ad, input [7:0] e);
      u_host.acc(1'b0, ad, 8'h00, d);
      chk("rdata", e, d);
   endtask
   // flip one event input, let the sync settle, read flags
   task flip(input integer b, input [7:0] e);
      @(posedge clk_i) ev[b] <= ~ev[b];
      repeat (5) @(posedge clk_i);
      chk("flags", e, f);
      rdc(8'h12, e);
   endtask
   task finish_test;
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge clk_i);
      nrst_i <= 1'b1;
      rdc(8'h0F, 8'hFF);
      rdc(8'h12, 8'h00);
      flip(0, 8'h00);
      flip(0, 8'h00);
      u_host.acc(1'b1, 8'h0F, 8'h00, d);
      for (i = 0; i < 4; i++) begin
         flip(i, 8'h10 << i);
         flip(i, 8'h10 << i);
      end
      flip(4, 8'h02);
      flip(4, 8'h02);
      $display("test events done");
      flip(5, 8'h08);
      chk("fault", 8'h01, {7'h00, fr});
      flip(5, 8'h00);
      chk("fault", 8'h00, {7'h00, fr});
      flip(6, 8'h04);
      chk("fault", 8'h01, {7'h00, fr});
      flip(6, 8'h00);
      $display("test power done");
      @(posedge clk_i) ev[1] <= ~ev[1];
      uv <= 1'b1;
      repeat (6) @(posedge clk_i);
      uv <= 1'b0;
      repeat (3) @(posedge clk_i);
      rdc(8'h12, 8'h00);
      rdc(8'h0F, 8'hFF);
      rdc(8'h33, 8'h00);
      $display("test reset done");
      finish_test;
   end
endmodule
